/* shared/sample_record_cfg.svh */
// Offsets, field positions, reset values and counts of the record builder
`ifndef SAMPLE_RECORD_CFG_SVH
`define SAMPLE_RECORD_CFG_SVH

// Group select bits, field positions and reset value of the configuration register
`define SRB_BIT_MEM 0
`define SRB_BIT_GPR 1
`define SRB_BIT_VEC 2
`define SRB_BIT_BR 3
`define SRB_GROUP_HI 3
`define SRB_RSV_HI 23
`define SRB_RSV_LO 4
`define SRB_CNT_HI 28
`define SRB_CNT_LO 24
`define SRB_CFG_RESET 64'h0000_0000_0000_0000

// Words (64 bit) per group, last word index of each group
`define SRB_BASIC_LAST 6'h03
`define SRB_MEM_LAST 6'h03
`define SRB_GPR_LAST 6'h11
`define SRB_VEC_LAST 6'h1F
`define SRB_BR_LAST 6'h02
`define SRB_BASIC_WORDS 11'h004
`define SRB_MEM_WORDS 11'h004
`define SRB_GPR_WORDS 11'h012
`define SRB_VEC_WORDS 11'h020
`define SRB_BR_WORDS 11'h003

// Highest branch stack index (stack depth minus one) implemented by the core
`define SRB_BR_DEPTH 5'h1F
// Record format code in the first basic word; value is arbitrary
`define SRB_FORMAT_CODE 16'h0001

`endif

/* shared/sample_record_pkg.sv */
// Types shared by the sample record builder modules
package sample_record_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_BASIC = 3'h1,
        ST_MEM   = 3'h3,
        ST_GPR   = 3'h2,
        ST_VEC   = 3'h6,
        ST_BR    = 3'h7
    } build_state_t;

    typedef struct packed {
        logic [63:0] cfg;
        logic fault;
    } cfg_state_t;

    typedef struct packed {
        logic [64:0] out;
        logic out_valid;
        logic [64:0] skid;
        logic skid_valid;
        logic in_ready;
    } buf_state_t;

    typedef struct packed {
        build_state_t st;
        logic busy;
        logic [5:0] cnt;
        logic [5:0] br_left;
        logic [4:0] br_idx;
        logic [3:0] groups;
        logic [15:0] size_bytes;
        logic [63:0] ip;
        logic [63:0] nip;
        logic [63:0] flags;
        logic [63:0] app;
        logic [63:0] tsc;
        logic [3:0][63:0] mem;
        logic [15:0][63:0] general_register_group;
        logic [15:0][127:0] vec;
    } build_state_s_t;

endpackage : sample_record_pkg

/* rtl/group_config_reg.sv */
// Record group configuration register with write checks
`timescale 1ns/100ps
`include "sample_record_cfg.svh"

module group_config_reg (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Software write port
    input wire logic i_wr,
    input wire logic [63:0] i_wdata,
    input wire logic i_monitor_available,
    // Register value and fault
    output logic [63:0] o_cfg,
    output logic o_fault
);
    sample_record_pkg::cfg_state_t q, d;
    logic [63:0] keep_mask;

    always_comb begin
        keep_mask = 64'h0;
        keep_mask[`SRB_GROUP_HI:0] = 4'hF;
        keep_mask[`SRB_CNT_HI:`SRB_CNT_LO] = 5'h1F;
        d = q;
        d.fault = 1'b0;
        // Writes are dropped while monitoring is unavailable
        if (i_wr && i_monitor_available) begin
            if (|i_wdata[`SRB_RSV_HI:`SRB_RSV_LO]) begin
                d.fault = 1'b1;
            end else begin
                // Count field takes entries minus one, five bits
                d.cfg = i_wdata & keep_mask;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{cfg: `SRB_CFG_RESET, fault: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_cfg = q.cfg;
    assign o_fault = q.fault;

    property p_rsv_fault;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_wr && i_monitor_available && |i_wdata[`SRB_RSV_HI:`SRB_RSV_LO])
        |=> (o_fault && $stable(o_cfg));
    endproperty
    a_rsv_fault: assert property (p_rsv_fault)
        else $error("reserved write did not fault");

    property p_unavail;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_wr && !i_monitor_available) |=> ($stable(o_cfg) && !o_fault);
    endproperty
    a_unavail: assert property (p_unavail)
        else $error("write taken while monitoring unavailable");
endmodule : group_config_reg

/* rtl/record_out_buffer.sv */
// Two-entry skid buffer between the builder and the record memory
`timescale 1ns/100ps

module record_out_buffer (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_valid,
    input wire logic [64:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [64:0] o_data,
    input wire logic i_ready
);
    sample_record_pkg::buf_state_t q, d;
    logic take;

    always_comb begin
        d = q;
        take = i_valid && q.in_ready;
        if (!q.out_valid || i_ready) begin
            if (q.skid_valid) begin
                d.out = q.skid;
                d.out_valid = 1'b1;
                d.skid_valid = take;
                d.skid = i_data;
            end else begin
                d.out = i_data;
                d.out_valid = take;
            end
        end else if (take) begin
            // Output stalled: park the word so nothing is lost
            d.skid = i_data;
            d.skid_valid = 1'b1;
        end
        d.in_ready = !d.skid_valid;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{out: 65'h0, out_valid: 1'b0, skid: 65'h0,
                   skid_valid: 1'b0, in_ready: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign o_ready = q.in_ready;
    assign o_valid = q.out_valid;
    assign o_data = q.out;

    property p_hold;
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_valid && !i_ready) |=> (o_valid && $stable(o_data));
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled word changed or dropped");
endmodule : record_out_buffer

/* rtl/adaptive_sample_record_builder.sv */
// Adaptive precise sample record builder: groups selected by config
`timescale 1ns/100ps
`include "sample_record_cfg.svh"

// Summary of operation
// - Config bit 0 adds memory group: address, source, latency.
// - Config bit 1 adds the general register group, else omitted.
// - Config bit 2 adds the vector register group.
// - Config bit 3 adds branch entries of source, destination, info.
// - Writing a one into reserved bits 23..4 faults, register kept.
// - Entry count field is entries minus one; 0x1F gives 32 entries.
// - Config writes ignored while monitoring-available flag is zero.
// - Basic group is always present whatever the config says.
// - Registers 64 bit; outside 64-bit mode upper halves, r8-r15 zero.
// - Order: flags, next pointer, ax cx dx bx sp bp si di, r8..r15.
// - Values are committed state right after the trigger completes.
// - Trigger pointer is the instruction; next pointer the following.
// - Vector slots 128 bit; zero if disabled; 8..15 zero outside 64b.
// - Each branch entry is three words: source, destination, info.
// - Entries start at stack top and descend, wrapping at depth.
// - Clear block flags pass unchanged; they do not imply no block.
// - Selected groups are packed with no gaps in the record.

module adaptive_sample_record_builder (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Configuration register access
    input wire logic i_cfg_wr,
    input wire logic [63:0] i_cfg_wdata,
    input wire logic i_monitor_available,
    output logic [63:0] o_cfg_rdata,
    output logic o_gp_fault,
    // Trigger and committed state
    input wire logic i_trigger,
    input wire logic i_long_mode,
    input wire logic i_vec_enable,
    input wire logic [63:0] i_trig_ip,
    input wire logic [63:0] i_next_ip,
    input wire logic [63:0] i_flags,
    input wire logic [15:0][63:0] i_gpr,
    input wire logic [15:0][127:0] i_vec,
    input wire logic [63:0] i_mem_addr,
    input wire logic [63:0] i_mem_aux,
    input wire logic [63:0] i_mem_lat,
    input wire logic [63:0] i_mem_txn,
    input wire logic [63:0] i_app_counters,
    input wire logic [63:0] i_timestamp,
    input wire logic [4:0] i_br_top,
    // Branch stack read port
    output logic [4:0] o_br_idx,
    input wire logic [63:0] i_br_from,
    input wire logic [63:0] i_br_to,
    input wire logic [63:0] i_br_info,
    // Record word stream
    output logic o_rec_valid,
    output logic [63:0] o_rec_data,
    output logic o_rec_last,
    input wire logic i_rec_ready,
    output logic o_busy
);
    sample_record_pkg::build_state_s_t q, d;
    logic [63:0] cfg, word;
    logic buf_ready, push, last_word;
    logic [10:0] nwords;
    logic [5:0] br_n;

    // ************************************************************
    // Configuration register
    // ************************************************************
    group_config_reg u_cfg (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_wr(i_cfg_wr),
        .i_wdata(i_cfg_wdata),
        .i_monitor_available(i_monitor_available),
        .o_cfg(cfg),
        .o_fault(o_gp_fault)
    );
    assign o_cfg_rdata = cfg;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Next selected group after s, in the fixed record order
    function automatic sample_record_pkg::build_state_t next_group(
        input sample_record_pkg::build_state_t s,
        input logic [3:0] g
    );
        logic before_mem, before_gpr, before_vec, before_br;
        before_mem = (s == sample_record_pkg::ST_BASIC);
        before_gpr = before_mem || (s == sample_record_pkg::ST_MEM);
        before_vec = before_gpr || (s == sample_record_pkg::ST_GPR);
        before_br = before_vec || (s == sample_record_pkg::ST_VEC);
        if (before_mem && g[`SRB_BIT_MEM]) begin
            return sample_record_pkg::ST_MEM;
        end else if (before_gpr && g[`SRB_BIT_GPR]) begin
            return sample_record_pkg::ST_GPR;
        end else if (before_vec && g[`SRB_BIT_VEC]) begin
            return sample_record_pkg::ST_VEC;
        end else if (before_br && g[`SRB_BIT_BR]) begin
            return sample_record_pkg::ST_BR;
        end
        return sample_record_pkg::ST_IDLE;
    endfunction : next_group

    // Index one below idx, wrapping at the implemented stack depth
    function automatic logic [4:0] br_prev(input logic [4:0] idx);
        if (idx == 5'h00) begin
            return `SRB_BR_DEPTH;
        end
        return idx - 5'h01;
    endfunction : br_prev

    // ************************************************************
    // Record sequencer
    // ************************************************************
    assign br_n = {1'b0, cfg[`SRB_CNT_HI:`SRB_CNT_LO]} + 6'h01;
    assign push = (q.st != sample_record_pkg::ST_IDLE) && buf_ready;

    always_comb begin
        d = q;
        last_word = 1'b0;
        nwords = `SRB_BASIC_WORDS;
        nwords = nwords + (cfg[`SRB_BIT_MEM] ? `SRB_MEM_WORDS : 11'h000);
        nwords = nwords + (cfg[`SRB_BIT_GPR] ? `SRB_GPR_WORDS : 11'h000);
        nwords = nwords + (cfg[`SRB_BIT_VEC] ? `SRB_VEC_WORDS : 11'h000);
        nwords = nwords + (cfg[`SRB_BIT_BR] ?
                           11'(`SRB_BR_WORDS * {5'h00, br_n}) : 11'h000);
        case (q.st)
            sample_record_pkg::ST_IDLE: begin
                if (i_trigger) begin
                    // Snapshot committed state of the trigger cycle
                    d.st = sample_record_pkg::ST_BASIC;
                    d.cnt = 6'h00;
                    d.groups = cfg[`SRB_GROUP_HI:0];
                    d.br_left = br_n;
                    d.br_idx = i_br_top;
                    d.size_bytes = {2'h0, nwords, 3'h0};
                    d.ip = i_trig_ip;
                    d.nip = i_next_ip;
                    d.flags = i_flags;
                    d.app = i_app_counters;
                    d.tsc = i_timestamp;
                    // Block flags pass through untouched
                    d.mem = {i_mem_txn, i_mem_lat, i_mem_aux, i_mem_addr};
                    for (int i = 0; i < 16; i++) begin
                        d.general_register_group[i] = i_gpr[i];
                        if (!i_long_mode) begin
                            d.general_register_group[i][63:32] = 32'h0;
                            if (i >= 8) begin
                                d.general_register_group[i] = 64'h0;
                            end
                        end
                        d.vec[i] = i_vec[i];
                        if (!i_vec_enable || (!i_long_mode && i >= 8)) begin
                            d.vec[i] = 128'h0;
                        end
                    end
                end
            end
            sample_record_pkg::ST_BASIC,
            sample_record_pkg::ST_MEM,
            sample_record_pkg::ST_GPR,
            sample_record_pkg::ST_VEC: begin
                if (push) begin
                    d.cnt = q.cnt + 6'h01;
                    if ((q.st == sample_record_pkg::ST_BASIC &&
                         q.cnt == `SRB_BASIC_LAST) ||
                        (q.st == sample_record_pkg::ST_MEM &&
                         q.cnt == `SRB_MEM_LAST) ||
                        (q.st == sample_record_pkg::ST_GPR &&
                         q.cnt == `SRB_GPR_LAST) ||
                        (q.st == sample_record_pkg::ST_VEC &&
                         q.cnt == `SRB_VEC_LAST)) begin
                        // Packed back to back in fixed order
                        d.st = next_group(q.st, q.groups);
                        d.cnt = 6'h00;
                    end
                    last_word = (d.st == sample_record_pkg::ST_IDLE);
                end
            end
            sample_record_pkg::ST_BR: begin
                if (push) begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == `SRB_BR_LAST) begin
                        d.cnt = 6'h00;
                        d.br_left = q.br_left - 6'h01;
                        d.br_idx = br_prev(q.br_idx);
                        if (q.br_left == 6'h01) begin
                            d.st = sample_record_pkg::ST_IDLE;
                            last_word = 1'b1;
                        end
                    end
                end
            end
            default: d.st = sample_record_pkg::ST_IDLE;
        endcase
        d.busy = (d.st != sample_record_pkg::ST_IDLE);
    end

    // ************************************************************
    // Word selection
    // ************************************************************
    always_comb begin
        word = 64'h0;
        case (q.st)
            sample_record_pkg::ST_BASIC: begin
                case (q.cnt[1:0])
                    2'h0: word = {q.size_bytes, 28'h0, q.groups,
                                  `SRB_FORMAT_CODE};
                    2'h1: word = q.ip;
                    2'h2: word = q.app;
                    default: word = q.tsc;
                endcase
            end
            sample_record_pkg::ST_MEM: word = q.mem[q.cnt[1:0]];
            sample_record_pkg::ST_GPR: begin
                // Flags, next pointer, then registers in slot order
                if (q.cnt == 6'h00) begin
                    word = q.flags;
                end else if (q.cnt == 6'h01) begin
                    word = q.nip;
                end else begin
                    word = q.general_register_group[4'(q.cnt - 6'h02)];
                end
            end
            sample_record_pkg::ST_VEC: begin
                // Low half of each slot first
                word = q.cnt[0] ? q.vec[q.cnt[4:1]][127:64]
                                : q.vec[q.cnt[4:1]][63:0];
            end
            sample_record_pkg::ST_BR: begin
                case (q.cnt[1:0])
                    2'h0: word = i_br_from;
                    2'h1: word = i_br_to;
                    default: word = i_br_info;
                endcase
            end
            default: word = 64'h0;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Output buffer
    // ************************************************************
    record_out_buffer u_buf (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_valid(q.st != sample_record_pkg::ST_IDLE),
        .i_data({last_word, word}),
        .o_ready(buf_ready),
        .o_valid(o_rec_valid),
        .o_data({o_rec_last, o_rec_data}),
        .i_ready(i_rec_ready)
    );
    assign o_br_idx = q.br_idx;
    assign o_busy = q.busy;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_take;
        (q.st == sample_record_pkg::ST_IDLE) && i_trigger;
    endsequence

    sequence s_leave_basic;
        (q.st == sample_record_pkg::ST_BASIC) && push &&
        (q.cnt == `SRB_BASIC_LAST);
    endsequence

    property p_basic_first;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take |=> (q.st == sample_record_pkg::ST_BASIC) && (q.cnt == 6'h00);
    endproperty
    a_basic_first: assert property (p_basic_first)
        else $error("record did not start with basic group");

    property p_mem_next;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_leave_basic and (q.groups[`SRB_BIT_MEM] == 1'b1)
        |=> (q.st == sample_record_pkg::ST_MEM);
    endproperty
    a_mem_next: assert property (p_mem_next)
        else $error("memory group not after basic");
    property p_gpr_sel;
        @(posedge i_clock) disable iff (!i_rst_n)
        (q.st == sample_record_pkg::ST_GPR) |-> q.groups[`SRB_BIT_GPR];
    endproperty
    a_gpr_sel: assert property (p_gpr_sel)
        else $error("general group emitted while unselected");
    property p_vec_sel;
        @(posedge i_clock) disable iff (!i_rst_n)
        (q.st == sample_record_pkg::ST_VEC) |-> q.groups[`SRB_BIT_VEC];
    endproperty
    a_vec_sel: assert property (p_vec_sel)
        else $error("vector group emitted while unselected");
    property p_br_count;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take |=> (q.br_left == $past(br_n)) && (q.br_idx == $past(i_br_top));
    endproperty
    a_br_count: assert property (p_br_count)
        else $error("branch count or start index wrong");
    property p_gpr_zero;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take and !i_long_mode
        |=> (q.general_register_group[8] == 64'h0) && (q.general_register_group[0][63:32] == 32'h0);
    endproperty
    a_gpr_zero: assert property (p_gpr_zero)
        else $error("general register not zeroed outside 64-bit mode");
    property p_vec_zero;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take and !i_vec_enable |=> (q.vec[0] == 128'h0);
    endproperty
    a_vec_zero: assert property (p_vec_zero)
        else $error("vector slot not zero with extension disabled");
    property p_br_desc;
        @(posedge i_clock) disable iff (!i_rst_n)
        ((q.st == sample_record_pkg::ST_BR) && push &&
         (q.cnt == `SRB_BR_LAST))
        |=> (o_br_idx == br_prev($past(o_br_idx)));
    endproperty
    a_br_desc: assert property (p_br_desc)
        else $error("branch index did not descend");
endmodule : adaptive_sample_record_builder

/* verification/record_far_side.sv */
// Far side model: branch stack read port and stalling record sink
`timescale 1ns/100ps

module record_far_side (
    // Clock
    input wire logic i_clock,
    // Branch stack, read without delay
    input wire logic [4:0] i_br_idx,
    output logic [63:0] o_br_from,
    output logic [63:0] o_br_to,
    output logic [63:0] o_br_info,
    // Sink; stall 0 prompt, 1 random, 2 held off
    input wire logic i_valid,
    input wire logic [63:0] i_data,
    input wire logic i_last,
    input wire logic [1:0] i_stall,
    output logic o_ready
);
    logic [63:0] stack [0:31][0:2];
    logic [64:0] words [$];
    integer seed = 32'h994fd936;
    initial begin
        o_ready = 1'b0;
        foreach (stack[i, j]) begin
            stack[i][j] = {$random(seed), $random(seed)};
        end
    end
    assign o_br_from = stack[i_br_idx][0];
    assign o_br_to = stack[i_br_idx][1];
    assign o_br_info = stack[i_br_idx][2];
    always @(posedge i_clock) begin
        if (i_valid && o_ready) begin
            words.push_back({i_last, i_data});
        end
        o_ready <= i_stall == 2'h0
            || (i_stall == 2'h1 && $random(seed) % 3 != 0);
    end
endmodule : record_far_side

/* verification/adaptive_sample_record_builder_tb_top.sv */
// Testbench of the sample record builder
`timescale 1ns/100ps
`include "sample_record_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin \
    $display("wrong value %s exp %h got %h", n, e, g); \
    bad_count++; end end

module adaptive_sample_record_builder_tb_top;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_cfg_wr = 1'b0, i_trigger = 1'b0;
    logic i_monitor_available = 1'b0, i_long_mode = 1'b0;
    logic i_vec_enable = 1'b0, i_rec_ready;
    logic [63:0] i_cfg_wdata = 64'h0, i_trig_ip, i_next_ip, i_flags;
    logic [63:0] i_mem_addr, i_mem_aux, i_mem_lat, i_mem_txn;
    logic [63:0] i_app_counters, i_timestamp, i_br_from, i_br_to, i_br_info;
    logic [15:0][63:0] i_gpr;
    logic [15:0][127:0] i_vec;
    logic [4:0] i_br_top, o_br_idx;
    logic [63:0] o_cfg_rdata, o_rec_data, cur_cfg = 64'h0;
    logic o_gp_fault, o_rec_valid, o_rec_last, o_busy;
    logic [1:0] stall_mode = 2'h0;
    logic [64:0] exp_q [$];
    // Odd counts keep records 16 byte aligned
    logic [63:0] cfgs [0:5] = '{64'h0, 64'h1F00_000F, 64'h4,
        64'h0300_000E, 64'h1, 64'h0000_000A};
    integer seed = 32'h994fd936, bad_count = 0, compares = 0, faults = 0;

    adaptive_sample_record_builder u_dut (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata),
        .i_monitor_available(i_monitor_available),
        .o_cfg_rdata(o_cfg_rdata), .o_gp_fault(o_gp_fault),
        .i_trigger(i_trigger), .i_long_mode(i_long_mode),
        .i_vec_enable(i_vec_enable), .i_trig_ip(i_trig_ip),
        .i_next_ip(i_next_ip), .i_flags(i_flags), .i_gpr(i_gpr),
        .i_vec(i_vec), .i_mem_addr(i_mem_addr), .i_mem_aux(i_mem_aux),
        .i_mem_lat(i_mem_lat), .i_mem_txn(i_mem_txn),
        .i_app_counters(i_app_counters), .i_timestamp(i_timestamp),
        .i_br_top(i_br_top), .o_br_idx(o_br_idx), .i_br_from(i_br_from),
        .i_br_to(i_br_to), .i_br_info(i_br_info), .o_busy(o_busy),
        .o_rec_valid(o_rec_valid), .o_rec_data(o_rec_data),
        .o_rec_last(o_rec_last), .i_rec_ready(i_rec_ready));
    record_far_side u_far (.i_clock(i_clock), .i_br_idx(o_br_idx),
        .o_br_from(i_br_from), .o_br_to(i_br_to), .o_br_info(i_br_info),
        .i_valid(o_rec_valid), .i_data(o_rec_data), .i_last(o_rec_last),
        .i_stall(stall_mode), .o_ready(i_rec_ready));

    initial begin
        forever #50 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (o_gp_fault === 1'b1) faults <= faults + 1;
    end

    // ****************
    // Tasks
    // ****************
    function automatic logic [63:0] r64();
        return {$random(seed), $random(seed)};
    endfunction : r64

    task automatic scramble();
        {i_trig_ip, i_next_ip, i_flags} = {r64(), r64(), r64()};
        // Aux block flags assume the store-forward event is counted
        {i_mem_addr, i_mem_aux, i_mem_lat, i_mem_txn} =
            {r64(), r64(), r64(), r64()};
        {i_app_counters, i_timestamp} = {r64(), r64()};
        i_br_top = 5'($random(seed));
        for (int i = 0; i < 16; i++) begin
            i_gpr[i] = r64();
            i_vec[i] = {r64(), r64()};
        end
    endtask : scramble

    task automatic cfg_write(input logic [63:0] d, input logic avail);
        integer f0;
        f0 = faults;
        @(negedge i_clock);
        i_cfg_wr = 1'b1;
        i_cfg_wdata = d;
        i_monitor_available = avail;
        @(negedge i_clock);
        i_cfg_wr = 1'b0;
        repeat (2) @(negedge i_clock);
        if (avail && d[23:4] != 20'h0) f0++;
        else if (avail) cur_cfg = d & 64'h1F00_000F;
        `CHK("fault count", f0, faults)
        `CHK("config", cur_cfg, o_cfg_rdata)
    endtask : cfg_write

    task automatic run_record(input logic [63:0] cfg, input logic [1:0] st);
        integer n;
        logic [4:0] idx;
        cfg_write(cfg, 1'b1);
        scramble();
        exp_q = {65'h0, i_trig_ip, i_app_counters, i_timestamp};
        if (cur_cfg[0]) begin
            exp_q = {exp_q, i_mem_addr, i_mem_aux, i_mem_lat, i_mem_txn};
        end
        if (cur_cfg[1]) begin
            exp_q = {exp_q, i_flags, i_next_ip};
            for (int i = 0; i < 16; i++) begin
                exp_q.push_back(i_long_mode ? i_gpr[i] : i < 8
                    ? {32'h0, i_gpr[i][31:0]} : 64'h0);
            end
        end
        for (int i = 0; i < 32 && cur_cfg[2]; i++) begin
            exp_q.push_back(i_vec_enable && (i_long_mode || i < 16)
                ? i_vec[i / 2][64 * (i % 2) +: 64] : 64'h0);
        end
        for (int k = 0; k <= cur_cfg[28:24] && cur_cfg[3]; k++) begin
            idx = i_br_top - 5'(k);
            for (int j = 0; j < 3; j++) begin
                exp_q.push_back(u_far.stack[idx][j]);
            end
        end
        n = exp_q.size();
        exp_q[0] = {1'b0, 16'(n * 8), 28'h0, cur_cfg[3:0], `SRB_FORMAT_CODE};
        exp_q[n - 1][64] = 1'b1;
        u_far.words.delete();
        stall_mode = st;
        i_trigger = 1'b1;
        @(negedge i_clock);
        // Second trigger lands while busy; state changes after capture
        scramble();
        @(negedge i_clock);
        i_trigger = 1'b0;
        if (st == 2'h2) begin
            repeat (12) @(negedge i_clock);
            `CHK("held valid", 1'b1, o_rec_valid)
            `CHK("held busy", 1'b1, o_busy)
            stall_mode = 2'h1;
        end
        for (n = 0; n < 3000 && (o_busy !== 1'b0
            || u_far.words.size() < exp_q.size()); n++) @(negedge i_clock);
        repeat (4) @(negedge i_clock);
        `CHK("record end", 1'b0, o_busy)
        `CHK("word count", exp_q.size(), u_far.words.size())
        foreach (exp_q[i]) `CHK("word", exp_q[i], u_far.words[i])
        $display("test record cfg %h done", cur_cfg);
    endtask : run_record

    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // ****************
    // Sequence
    // ****************
    initial begin
        scramble();
        repeat (2) @(negedge i_clock);
        i_rst_n = 1'b1;
        `CHK("reset config", 64'h0, o_cfg_rdata)
        cfg_write(64'h0000_000F, 1'b0);
        cfg_write(64'h0000_0013, 1'b1);
        cfg_write(64'h0080_0000, 1'b1);
        cfg_write(64'hFFFF_FFFF_E000_0003, 1'b1);
        $display("test config writes done");
        for (int r = 0; r < 2; r++) begin
            foreach (cfgs[j]) begin
                i_long_mode = r[0];
                i_vec_enable = j[0];
                run_record(cfgs[j], j == 3 ? 2'h2 : 2'h1);
            end
        end
        conclude();
    end
    initial begin
        repeat (40000) @(posedge i_clock);
        bad_count++;
        conclude();
    end
endmodule : adaptive_sample_record_builder_tb_top
